// ===== pwmdt_core.sv
// Purpose: Dead-time registers and edge delay for one PWM generator.
// Assumes: Raw PWM drive inputs synchronous to mclk; APB slave.
// Notes:   Ready is given one cycle into the access phase.
`timescale 1ns/100ps

// Operation
// - Low-side delay held in bits 13..0 of low dead-time register, read/write.
// - Without high-resolution mode, low-side bits 13..11 are unused in the delay.
// - High-side delay held in bits 13..0 of high dead-time register, read/write.
// - Without high-resolution mode, high-side bits 13..11 are unused in the delay.
// - Bits 15 and 14 of each dead-time register ignore writes, read zero.
module pwmdt_core import pwmdt_pkg::*; (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // PWM drive
    input  wire logic        raw_low,
    input  wire logic        raw_high,
    output logic             low_side_output,
    output logic             high_side_output
);
    pwmdt_state_t st_reg;
    pwmdt_state_t st_next;

    // Masks the delay to the usable width for the current mode.
    function automatic logic [13:0] eff_delay(input logic [13:0] v, input logic hres);
        eff_delay = hres ? v : {3'h0, v[PWMDT_STD_MSB:0]};
    endfunction

    // Returns true for a mapped register address.
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == PWMDT_LOW_OFS) || (a == PWMDT_HIGH_OFS) ||
                  (a == PWMDT_CTRL_OFS) || (a == PWMDT_STAT_OFS);
    endfunction

    logic        acc;
    logic        wr_commit;
    logic [13:0] low_eff;
    logic [13:0] high_eff;
    assign acc       = psel && penable && !st_reg.pready;
    assign wr_commit = psel && penable && pwrite && st_reg.pready;
    assign low_eff  = eff_delay(st_reg.low_side_delay_value, st_reg.high_resolution_mode_bit);
    assign high_eff = eff_delay(st_reg.high_side_delay_value, st_reg.high_resolution_mode_bit);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next         = st_reg;
        st_next.pslverr = 1'b0;
        st_next.pready  = acc;
        // Writes land on the edge at which the master sees pready high.
        if (wr_commit) begin
            case (paddr)
                PWMDT_LOW_OFS:  st_next.low_side_delay_value = pwdata[13:0];
                PWMDT_HIGH_OFS: st_next.high_side_delay_value = pwdata[13:0];
                PWMDT_CTRL_OFS: begin
                    st_next.high_resolution_mode_bit = pwdata[PWMDT_HRES_POS];
                    st_next.enable                   = pwdata[PWMDT_EN_POS];
                end
                default: ;
            endcase
        end
        if (acc) begin
            st_next.pslverr = !addr_ok(paddr);
            st_next.prdata  = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    PWMDT_LOW_OFS:  st_next.prdata = {18'h0, st_reg.low_side_delay_value};
                    PWMDT_HIGH_OFS: st_next.prdata = {18'h0, st_reg.high_side_delay_value};
                    PWMDT_CTRL_OFS: st_next.prdata = {24'h0, st_reg.high_resolution_mode_bit,
                                                      6'h0, st_reg.enable};
                    PWMDT_STAT_OFS: st_next.prdata = {30'h0, st_reg.high_side_output,
                                                      st_reg.low_side_output};
                    default:        st_next.prdata = 32'h0000_0000;
                endcase
            end
        end
        // Rising edges wait out the delay; falling edges pass at once.
        st_next.raw_low_q  = raw_low;
        st_next.raw_high_q = raw_high;
        if (!raw_low || !st_reg.enable) begin
            st_next.low_cnt         = 14'h0000;
            st_next.low_side_output = 1'b0;
        end else if (st_reg.low_cnt >= low_eff) begin
            st_next.low_side_output = 1'b1;
        end else begin
            st_next.low_cnt = st_reg.low_cnt + 14'h0001;
        end
        if (!raw_high || !st_reg.enable) begin
            st_next.high_cnt         = 14'h0000;
            st_next.high_side_output = 1'b0;
        end else if (st_reg.high_cnt >= high_eff) begin
            st_next.high_side_output = 1'b1;
        end else begin
            st_next.high_cnt = st_reg.high_cnt + 14'h0001;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg                       <= '0;
            st_reg.low_side_delay_value  <= PWMDT_DLY_RST;
            st_reg.high_side_delay_value <= PWMDT_DLY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata           = st_reg.prdata;
    assign pready           = st_reg.pready;
    assign pslverr          = st_reg.pslverr;
    assign low_side_output  = st_reg.low_side_output;
    assign high_side_output = st_reg.high_side_output;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence acc_s;
        psel && penable && !pready;
    endsequence

    sequence low_wr_s;
        psel && penable && pready && pwrite && paddr == PWMDT_LOW_OFS;
    endsequence

    sequence high_wr_s;
        psel && penable && pready && pwrite && paddr == PWMDT_HIGH_OFS;
    endsequence

    sequence ctrl_wr_s;
        psel && penable && pready && pwrite && paddr == PWMDT_CTRL_OFS;
    endsequence

    sequence low_rd_s;
        psel && penable && !pready && !pwrite && paddr == PWMDT_LOW_OFS;
    endsequence

    sequence high_rd_s;
        psel && penable && !pready && !pwrite && paddr == PWMDT_HIGH_OFS;
    endsequence

    // ************************************************************
    // Bus handshake
    // ************************************************************

    rdy_answer_a: assert property (acc_s |=> pready)
        else $error("access not answered");

    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");

    rdy_idle_a: assert property (!(psel && penable) |=> !pready)
        else $error("ready without access");

    err_with_rdy_a: assert property (pslverr |-> pready)
        else $error("error without ready");

    err_unmapped_a: assert property (acc_s ##0 !addr_ok(paddr) |=> pslverr)
        else $error("unmapped access not flagged");

    err_mapped_a: assert property (acc_s ##0 addr_ok(paddr) |=> !pslverr)
        else $error("mapped access flagged");

    wr_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("write returned data");

    // ************************************************************
    // Register storage
    // ************************************************************

    low_store_a: assert property (low_wr_s |=> st_reg.low_side_delay_value == $past(pwdata[13:0]))
        else $error("low delay not stored");

    high_store_a: assert property (high_wr_s
        |=> st_reg.high_side_delay_value == $past(pwdata[13:0]))
        else $error("high delay not stored");

    ctrl_store_a: assert property (ctrl_wr_s
        |=> st_reg.high_resolution_mode_bit == $past(pwdata[PWMDT_HRES_POS])
            && st_reg.enable == $past(pwdata[PWMDT_EN_POS]))
        else $error("control not stored");

    low_hold_a: assert property (!(psel && penable && pready && pwrite)
        |=> $stable(st_reg.low_side_delay_value))
        else $error("low delay changed without write");

    high_hold_a: assert property (!(psel && penable && pready && pwrite)
        |=> $stable(st_reg.high_side_delay_value))
        else $error("high delay changed without write");

    ctrl_hold_a: assert property (!(psel && penable && pready && pwrite)
        |=> $stable(st_reg.high_resolution_mode_bit) && $stable(st_reg.enable))
        else $error("control changed without write");

    // ************************************************************
    // Read back
    // ************************************************************

    unimpl_read_a: assert property (pready && (paddr == PWMDT_LOW_OFS || paddr == PWMDT_HIGH_OFS)
        |-> prdata[31:14] == 18'h0)
        else $error("unimplemented bits read nonzero");

    high_unimpl_a: assert property (pready && !pwrite && paddr == PWMDT_HIGH_OFS
        |-> prdata[15:14] == 2'h0)
        else $error("high unimplemented bits nonzero");

    low_read_a: assert property (low_rd_s
        |=> prdata == {18'h0, $past(st_reg.low_side_delay_value)})
        else $error("low delay read wrong");

    high_read_a: assert property (high_rd_s
        |=> prdata == {18'h0, $past(st_reg.high_side_delay_value)})
        else $error("high delay read wrong");

    ctrl_read_a: assert property (acc_s ##0 !pwrite && paddr == PWMDT_CTRL_OFS
        |=> prdata[PWMDT_HRES_POS] == $past(st_reg.high_resolution_mode_bit)
            && prdata[PWMDT_EN_POS] == $past(st_reg.enable))
        else $error("control read wrong");

    stat_read_a: assert property (acc_s ##0 !pwrite && paddr == PWMDT_STAT_OFS
        |=> prdata[1:0] == $past({high_side_output, low_side_output}))
        else $error("status read wrong");

    unmap_read_a: assert property (acc_s ##0 !pwrite && !addr_ok(paddr)
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read nonzero");

    // ************************************************************
    // Delay masking
    // ************************************************************

    low_mask_a: assert property (!st_reg.high_resolution_mode_bit |-> low_eff[13:11] == 3'h0)
        else $error("low delay upper bits used");

    high_mask_a: assert property (!st_reg.high_resolution_mode_bit |-> high_eff[13:11] == 3'h0)
        else $error("high delay upper bits used");

    low_lsb_a: assert property (!st_reg.high_resolution_mode_bit
        |-> low_eff[10:0] == st_reg.low_side_delay_value[10:0])
        else $error("low delay lower bits lost");

    high_lsb_a: assert property (!st_reg.high_resolution_mode_bit
        |-> high_eff[10:0] == st_reg.high_side_delay_value[10:0])
        else $error("high delay lower bits lost");

    low_full_a: assert property (st_reg.high_resolution_mode_bit
        |-> low_eff == st_reg.low_side_delay_value)
        else $error("low delay cut in high resolution");

    high_full_a: assert property (st_reg.high_resolution_mode_bit
        |-> high_eff == st_reg.high_side_delay_value)
        else $error("high delay cut in high resolution");

    // ************************************************************
    // Edge delay
    // ************************************************************

    zero_delay_a: assert property (st_reg.enable && low_eff == 14'h0 && $rose(raw_low)
        ##1 raw_low |=> low_side_output)
        else $error("zero delay edge late");

    high_zero_a: assert property (st_reg.enable && high_eff == 14'h0 && $rose(raw_high)
        ##1 raw_high |=> high_side_output)
        else $error("high zero delay edge late");

    low_early_a: assert property ($rose(low_side_output) |-> $past(raw_low) && $past(st_reg.enable))
        else $error("low output rose without drive");

    high_early_a: assert property ($rose(high_side_output)
        |-> $past(raw_high) && $past(st_reg.enable))
        else $error("high output rose without drive");

    low_due_a: assert property ($rose(low_side_output) |-> $past(st_reg.low_cnt >= low_eff))
        else $error("low output rose before delay");

    high_due_a: assert property ($rose(high_side_output) |-> $past(st_reg.high_cnt >= high_eff))
        else $error("high output rose before delay");

    low_step_a: assert property (raw_low && st_reg.enable && st_reg.low_cnt < low_eff
        |=> st_reg.low_cnt == $past(st_reg.low_cnt) + 14'h0001)
        else $error("low delay count stalled");

    high_step_a: assert property (raw_high && st_reg.enable && st_reg.high_cnt < high_eff
        |=> st_reg.high_cnt == $past(st_reg.high_cnt) + 14'h0001)
        else $error("high delay count stalled");

    fall_fast_a: assert property (!raw_high |=> !high_side_output)
        else $error("high output not released");

    low_fall_a: assert property (!raw_low |=> !low_side_output)
        else $error("low output not released");

    low_clear_a: assert property (!raw_low |=> st_reg.low_cnt == 14'h0000)
        else $error("low delay count not cleared");

    high_clear_a: assert property (!raw_high |=> st_reg.high_cnt == 14'h0000)
        else $error("high delay count not cleared");

    low_off_a: assert property (!st_reg.enable |=> !low_side_output)
        else $error("low output while disabled");

    high_off_a: assert property (!st_reg.enable |=> !high_side_output)
        else $error("high output while disabled");

    // ************************************************************
    // Reset
    // ************************************************************

    rst_delay_a: assert property (disable iff (1'b0) rst
        |=> st_reg.low_side_delay_value == PWMDT_DLY_RST && st_reg.high_side_delay_value == PWMDT_DLY_RST)
        else $error("delays not cleared by reset");

    rst_out_a: assert property (disable iff (1'b0) rst
        |=> !low_side_output && !high_side_output && !pready && !pslverr)
        else $error("outputs not cleared by reset");
endmodule // pwmdt_core

// ===== pwmdt_pkg.sv
// Purpose: Shared constants and types for the PWM dead-time block.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes:   Offsets are byte addresses.
package pwmdt_pkg;
    localparam logic [11:0] PWMDT_LOW_OFS   = 12'h000;
    localparam logic [11:0] PWMDT_HIGH_OFS  = 12'h004;
    localparam logic [11:0] PWMDT_CTRL_OFS  = 12'h008;
    localparam logic [11:0] PWMDT_STAT_OFS  = 12'h00C;
    localparam int          PWMDT_DLY_W     = 14;
    localparam int          PWMDT_FULL_MSB  = 13;
    localparam int          PWMDT_STD_MSB   = 10;
    localparam int          PWMDT_HRES_POS  = 7;
    localparam int          PWMDT_EN_POS    = 0;
    localparam logic [13:0] PWMDT_DLY_RST   = 14'h0000;

    typedef struct packed {
        logic [13:0] low_side_delay_value;
        logic [13:0] high_side_delay_value;
        logic        high_resolution_mode_bit;
        logic        enable;
        logic        raw_low_q;
        logic        raw_high_q;
        logic [13:0] low_cnt;
        logic [13:0] high_cnt;
        logic        low_side_output;
        logic        high_side_output;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pwmdt_state_t;
endpackage : pwmdt_pkg

// ===== pwmdt_tb.sv
// Purpose: Self-checking bench for the PWM dead-time block.
// Assumes: APB master driven at rising edges; pready answers each access.
// Notes:   Delays are measured in mclk cycles from a raw rising edge.
`timescale 1ns/100ps
module testbench import pwmdt_pkg::*;;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, raw_low = 0, raw_high = 0;
    logic        low_side_output, high_side_output;
    int          num_errors = 0, tests_run = 0;
    always #5 mclk = ~mclk;
    pwmdt_core dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_low(raw_low), .raw_high(raw_high), .low_side_output(low_side_output),
        .high_side_output(high_side_output));
    // ****************************************
    // Tasks
    // ****************************************
    task close_out;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(0, 1, "apb timeout");
        if (n >= 20) close_out();
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask
    task dly(input bit hi, input int d);
        int n;
        if (hi) raw_high <= 1'b1;
        else raw_low <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while ((hi ? high_side_output : low_side_output) !== 1'b1 && n < 5000);
        chk(n, d + 1, "rise delay");
        if (n >= 5000) close_out();
        @(posedge mclk);
        raw_low <= 1'b0; raw_high <= 1'b0;
        @(posedge mclk);
        #1 chk((hi ? high_side_output : low_side_output), 0, "fall");
        @(posedge mclk);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(0, PWMDT_LOW_OFS, 0); chk(rd, 0, "low reset");
        apb(0, PWMDT_HIGH_OFS, 0); chk(rd, 0, "high reset");
        apb(1, PWMDT_LOW_OFS, 32'hFFFFFFFF);
        apb(0, PWMDT_LOW_OFS, 0); chk(rd, 32'h00003FFF, "low width");
        apb(1, PWMDT_HIGH_OFS, 32'hFFFFFFFF);
        apb(0, PWMDT_HIGH_OFS, 0); chk(rd, 32'h00003FFF, "high width");
        apb(0, 12'h010, 0); chk({rd[30:0], er}, 32'h1, "unmapped");
        apb(1, PWMDT_CTRL_OFS, 32'h00000001);
        apb(1, PWMDT_LOW_OFS, 32'h00000803);
        dly(0, 3);
        apb(1, PWMDT_HIGH_OFS, 32'h00001004);
        dly(1, 4);
        apb(0, PWMDT_HIGH_OFS, 0); chk(rd, 32'h00001004, "high kept");
        apb(1, PWMDT_CTRL_OFS, 32'h00000081);
        apb(0, PWMDT_CTRL_OFS, 0); chk(rd, 32'h00000081, "ctrl kept");
        dly(1, 32'h1004);
        dly(0, 32'h0803);
        apb(1, PWMDT_CTRL_OFS, 32'h00000001);
        apb(1, PWMDT_LOW_OFS, 32'h00000800);
        apb(1, PWMDT_HIGH_OFS, 32'h00003800);
        dly(0, 0);
        dly(1, 0);
        apb(0, PWMDT_STAT_OFS, 0); chk(rd, 0, "outputs idle");
        rst <= 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(0, PWMDT_LOW_OFS, 0); chk(rd, 0, "low cleared");
        apb(0, PWMDT_HIGH_OFS, 0); chk(rd, 0, "high cleared");
        apb(0, PWMDT_CTRL_OFS, 0); chk(rd, 0, "ctrl cleared");
        close_out();
    end
endmodule // testbench
